// ===== bench/tb_wakeup_and_sleep_io_control.sv
// self-checking bench for the wake-up and sleep io register block
`timescale 1ns/1ns
`default_nettype none
`include "wsc_cfg.svh"
module tb_wakeup_and_sleep_io_control;
    import wsc_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic        hready, hreadyout, hresp, sys_clk_from_ring, slow_clk_from_xtal;
    logic        fast_xtal_ready = 1'b0, slow_xtal_select = 1'b0, low_power = 1'b0;
    logic        core_clk_fast, periph_clk_halved, fast_crystal_flag, wake_event, core_reset;
    wsc_pad_s    pad_ctrl;
    logic [4:0]  pad_out, pad_oe, wake_pin, pin_en = 5'h00, pin_lvl = 5'h00;
    int          num_errors = 0, checked = 0, cycles = 0;
    localparam logic [11:0] OFS [8] = '{`WSC_OFS_LEVEL, `WSC_OFS_WAKE_EN, `WSC_OFS_XTAL,
        `WSC_OFS_OEN, `WSC_OFS_OUT, `WSC_OFS_DS, `WSC_OFS_PE, `WSC_OFS_CONV_CMD};
    localparam logic [31:0] RST [8] = '{32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] MSK [8] = '{32'h1F, 32'h1F, 32'h1, 32'h1F, 32'h1F, 32'h1F, 32'h1F,
        32'hFF};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // 100 MHz clock
    always #5 hclk = ~hclk;

    wsc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .fast_xtal_ready, .slow_xtal_select, .low_power,
        .sys_clk_from_ring, .slow_clk_from_xtal, .core_clk_fast, .periph_clk_halved,
        .fast_crystal_flag, .wake_pin, .wake_event, .core_reset, .pad_ctrl, .pad_out, .pad_oe);

    wsc_pin_model pins (.hclk, .drive_en(pin_en), .level(pin_lvl), .wake_pin);

    task automatic summarize;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // one word transfer, address phase then data phase
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `WSC_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= `WSC_HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(a, 1'b1, d, t);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(a, 1'b0, 32'h0, t);
        chk(what, t, exp);
    endtask

    task automatic test_regs;
        for (int i = 0; i < 8; i++) rdchk("reset value", OFS[i], RST[i]);
        for (int i = 0; i < 8; i++) begin
            wr(OFS[i], 32'hFFFFFFFF);
            rdchk("writable bits", OFS[i], MSK[i]);
            wr(OFS[i], 32'h0);
            rdchk("cleared bits", OFS[i], 32'h0);
        end
        wr(12'h020, 32'hFFFFFFFF);
        rdchk("unmapped word", 12'h020, 32'h0);
        $display("test regs done");
    endtask

    task automatic test_pads;
        wr(`WSC_OFS_OEN, 32'h05);
        wr(`WSC_OFS_OUT, 32'h1F);
        wr(`WSC_OFS_DS, 32'h0A);
        wr(`WSC_OFS_PE, 32'h11);
        tick(1);
        chk("pad_oe", pad_oe, 32'h05);
        chk("drive enable", pad_ctrl.drive_enable, 32'h05);
        chk("value field", pad_ctrl.value, 32'h1F);
        chk("pad_out", pad_out, 32'h05);
        chk("strength", pad_ctrl.strength, 32'h0A);
        chk("pull", pad_ctrl.pull, 32'h11);
        rdchk("value readback", `WSC_OFS_OUT, 32'h1F);
        $display("test pads done");
    endtask

    task automatic test_clocks;
        for (int v = 0; v < 2; v++) begin
            fast_xtal_ready <= v[0];
            slow_xtal_select <= v[0];
            tick(2);
            chk("sys clock from ring", sys_clk_from_ring, !v[0]);
            chk("slow clock from xtal", slow_clk_from_xtal, v[0]);
        end
        wr(`WSC_OFS_CONV_CMD, `WSC_CMD_FAST);
        tick(12);
        chk("fast without flag", core_clk_fast, 32'h0);
        wr(`WSC_OFS_CONV_CMD, `WSC_CMD_SLOW);
        wr(`WSC_OFS_XTAL, 32'h1);
        tick(1);
        chk("crystal flag", fast_crystal_flag, 32'h1);
        chk("halved branches", periph_clk_halved, 32'h1);
        wr(`WSC_OFS_CONV_CMD, `WSC_CMD_FAST);
        tick(9);
        chk("fast too early", core_clk_fast, 32'h0);
        tick(1);
        chk("fast after switch", core_clk_fast, 32'h1);
        wr(`WSC_OFS_CONV_CMD, `WSC_CMD_SLOW);
        tick(2);
        chk("back to slow", core_clk_fast, 32'h0);
        wr(`WSC_OFS_XTAL, 32'h0);
        tick(1);
        chk("halving off", periph_clk_halved, 32'h0);
        $display("test clocks done");
    endtask

    task automatic test_wake;
        low_power <= 1'b1;
        pin_en <= 5'h1F;
        wr(`WSC_OFS_LEVEL, 32'h0A);
        for (int i = 0; i < 5; i++) begin
            wr(`WSC_OFS_WAKE_EN, 32'h1 << i);
            pin_lvl <= 5'h15;
            tick(2);
            chk("idle pins", wake_event, 32'h0);
            pin_lvl <= 5'h15 ^ (5'h01 << ((i + 1) % 5));
            tick(2);
            chk("blocked pin", wake_event, 32'h0);
            pin_lvl <= 5'h15 ^ (5'h01 << i);
            tick(2);
            chk("enabled pin", wake_event, 32'h1);
            pin_lvl <= 5'h15;
            tick(2);
            chk("core reset on", core_reset, 32'h1);
            tick(2);
            chk("core reset held", core_reset, 32'h1);
            tick(1);
            chk("core reset off", core_reset, 32'h0);
        end
        $display("test wake done");
    endtask

    // main sequence
    initial begin
        hresetn <= 1'b0;
        tick(8);
        hresetn <= 1'b1;
        tick(1);
        test_regs();
        test_pads();
        test_clocks();
        test_wake();
        summarize();
    end
endmodule
`default_nettype wire

// ===== bench/wsc_pin_model.sv
// external circuits that drive the wake-capable pins
`timescale 1ns/1ns
`default_nettype none
module wsc_pin_model (
    // clock
    input  wire logic       hclk,
    // drive command from the bench
    input  wire logic [4:0] drive_en,
    input  wire logic [4:0] level,
    // pins
    output logic      [4:0] wake_pin
);
    logic [4:0] last_ff = 5'h00;

    // remember the level each pin was last driven to
    always @(posedge hclk) last_ff <= (drive_en & level) | (~drive_en & last_ff);

    // pins 0..2 have pull-ups, released pins 3..4 show the inverse of their last level
    assign wake_pin = (drive_en & level) | (~drive_en & {~last_ff[4:3], 3'h7});
endmodule
`default_nettype wire

// ===== core/wsc_cfg.svh
// constants for the wake-up and sleep io control block
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH
`define WSC_NPINS           5
`define WSC_OFS_LEVEL       12'h000
`define WSC_OFS_WAKE_EN     12'h004
`define WSC_OFS_XTAL        12'h008
`define WSC_OFS_OEN         12'h00C
`define WSC_OFS_OUT         12'h010
`define WSC_OFS_DS          12'h014
`define WSC_OFS_PE          12'h018
`define WSC_OFS_CONV_CMD    12'h01C
`define WSC_RST_LEVEL       5'h00
`define WSC_RST_WAKE_EN     5'h07
`define WSC_RST_XTAL        1'h0
`define WSC_RST_OEN         5'h07
`define WSC_RST_OUT         5'h00
`define WSC_RST_DS          5'h00
`define WSC_RST_PE          5'h00
`define WSC_RST_CMD         8'h00
`define WSC_CMD_FAST        8'h15
`define WSC_CMD_SLOW        8'h14
`define WSC_SWITCH_CYCLES   4'hA
`define WSC_CORE_RST_CYCLES 4'h4
`define WSC_HTRANS_NONSEQ   2'h2
`define WSC_HSIZE_WORD      3'h2
`endif

// ===== core/wsc_pkg.sv
// types shared by the wake-up and sleep io control block
package wsc_pkg;
    typedef enum logic [1:0] {WSC_RATE_SLOW, WSC_RATE_SWITCH, WSC_RATE_FAST} wsc_rate_e;
    // per-pin low-power pad controls
    typedef struct packed {
        logic [4:0] drive_enable;
        logic [4:0] value;
        logic [4:0] strength;
        logic [4:0] pull;
    } wsc_pad_s;
endpackage

// ===== core/wsc_top.sv
// register bank for wake-up pins, retained io and clock rate control
// Contract
// - each level bit picks the wake level of its pin, 0 low and 1 high, bits 0..4 for pins 0..4.
// - each enable bit allows or blocks its pin as wake source, reset leaves pins 0..2 on.
// - bit 0 of the crystal register says 16 MHz (0) or 32 MHz (1), reset 16 MHz.
// - each low-power drive-enable bit makes its retained pin an output, reset pins 0..2.
// - a written value bit is driven only when enabled, and reads back as written.
// - each strength bit picks low (0) or high (1) drive, reset all low.
// - each pull bit enables its pull, reset all off.
// - the slow clock comes from the slow crystal or the internal ring oscillator.
// - while the fast crystal starts up the fast ring oscillator clocks the system.
// - with 32 MHz only core, dma and peripheral bus run fast, the rest runs halved.
// - writing 0x14 to the converter returns bus and core to 16 MHz.
// - a decision to leave sleep or standby resets the core logic.
`timescale 1ns/1ns
`default_nettype none
`include "wsc_cfg.svh"
module wsc_top
    import wsc_pkg::*;
#(
    parameter int NPINS = `WSC_NPINS
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [11:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // oscillator status
    input  wire logic             fast_xtal_ready,
    input  wire logic             slow_xtal_select,
    input  wire logic             low_power,
    // clock steering
    output logic                  sys_clk_from_ring,
    output logic                  slow_clk_from_xtal,
    output logic                  core_clk_fast,
    output logic                  periph_clk_halved,
    output logic                  fast_crystal_flag,
    // wake pins and retained pads
    input  wire logic [NPINS-1:0] wake_pin,
    output logic                  wake_event,
    output logic                  core_reset,
    output wsc_pad_s              pad_ctrl,
    output logic [NPINS-1:0]      pad_out,
    output logic [NPINS-1:0]      pad_oe
);
    // elaboration guard on the pin count
    if (NPINS != `WSC_NPINS) begin : g_bad_npins
        $error("only five wake pins are supported");
    end

    // registers
    logic [NPINS-1:0] level_ff;
    logic [NPINS-1:0] wake_en_ff;
    logic [NPINS-1:0] oen_ff;
    logic [NPINS-1:0] out_ff;
    logic [NPINS-1:0] ds_ff;
    logic [NPINS-1:0] pe_ff;
    logic             xtal_ff;
    logic [7:0]       cmd_ff;
    logic [11:0]      addr_ff;
    logic             wr_ff;
    logic             rd_ff;
    wsc_rate_e        rate_ff;
    wsc_rate_e        nxt_rate;
    logic [3:0]       sw_cnt_ff;
    logic [3:0]       nxt_sw_cnt;
    logic [31:0]      nxt_hrdata;

    // address phase decode, and data phase write strobes from the registered address
    wire        valid_req = hsel & hready & (htrans == `WSC_HTRANS_NONSEQ);
    wire        wr_req    = valid_req & hwrite;
    wire        rd_req    = valid_req & ~hwrite;
    wire        wr_level  = wr_ff & (addr_ff == `WSC_OFS_LEVEL);
    wire        wr_wake   = wr_ff & (addr_ff == `WSC_OFS_WAKE_EN);
    wire        wr_xtal   = wr_ff & (addr_ff == `WSC_OFS_XTAL);
    wire        wr_oen    = wr_ff & (addr_ff == `WSC_OFS_OEN);
    wire        wr_out    = wr_ff & (addr_ff == `WSC_OFS_OUT);
    wire        wr_ds     = wr_ff & (addr_ff == `WSC_OFS_DS);
    wire        wr_pe     = wr_ff & (addr_ff == `WSC_OFS_PE);
    wire        wr_cmd    = wr_ff & (addr_ff == `WSC_OFS_CONV_CMD);
    wire [11:0] ra        = {haddr[11:2], 2'b00};

    // next register values, a write in its data phase takes effect
    wire [NPINS-1:0] nxt_level   = wr_level ? hwdata[NPINS-1:0] : level_ff;
    wire [NPINS-1:0] nxt_wake_en = wr_wake  ? hwdata[NPINS-1:0] : wake_en_ff;
    wire             nxt_xtal    = wr_xtal  ? hwdata[0]         : xtal_ff;
    wire [NPINS-1:0] nxt_oen     = wr_oen   ? hwdata[NPINS-1:0] : oen_ff;
    wire [NPINS-1:0] nxt_out     = wr_out   ? hwdata[NPINS-1:0] : out_ff;
    wire [NPINS-1:0] nxt_ds      = wr_ds    ? hwdata[NPINS-1:0] : ds_ff;
    wire [NPINS-1:0] nxt_pe      = wr_pe    ? hwdata[NPINS-1:0] : pe_ff;
    wire [7:0]       nxt_cmd     = wr_cmd   ? hwdata[7:0]       : cmd_ff;

    // read mux sees a pending write, reserved and unmapped bits zero
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        unique case (ra)
            `WSC_OFS_LEVEL:    nxt_hrdata[NPINS-1:0] = nxt_level;
            `WSC_OFS_WAKE_EN:  nxt_hrdata[NPINS-1:0] = nxt_wake_en;
            `WSC_OFS_XTAL:     nxt_hrdata[0]         = nxt_xtal;
            `WSC_OFS_OEN:      nxt_hrdata[NPINS-1:0] = nxt_oen;
            `WSC_OFS_OUT:      nxt_hrdata[NPINS-1:0] = nxt_out;
            `WSC_OFS_DS:       nxt_hrdata[NPINS-1:0] = nxt_ds;
            `WSC_OFS_PE:       nxt_hrdata[NPINS-1:0] = nxt_pe;
            `WSC_OFS_CONV_CMD: nxt_hrdata[7:0]       = nxt_cmd;
            default:           nxt_hrdata = 32'h0000_0000;
        endcase
    end

    // bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 12'h000;
            wr_ff   <= 1'b0;
            rd_ff   <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end else begin
            addr_ff <= {haddr[11:2], 2'b00};
            wr_ff   <= wr_req;
            rd_ff   <= rd_req;
            hrdata  <= rd_req ? nxt_hrdata : hrdata;
        end
    end

    // zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // register writes, only low bits kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_ff   <= `WSC_RST_LEVEL;
            wake_en_ff <= `WSC_RST_WAKE_EN;
            xtal_ff    <= `WSC_RST_XTAL;
            oen_ff     <= `WSC_RST_OEN;
            out_ff     <= `WSC_RST_OUT;
            ds_ff      <= `WSC_RST_DS;
            pe_ff      <= `WSC_RST_PE;
            cmd_ff     <= `WSC_RST_CMD;
        end else begin
            level_ff   <= nxt_level;
            wake_en_ff <= nxt_wake_en;
            xtal_ff    <= nxt_xtal;
            oen_ff     <= nxt_oen;
            out_ff     <= nxt_out;
            ds_ff      <= nxt_ds;
            pe_ff      <= nxt_pe;
            cmd_ff     <= nxt_cmd;
        end
    end

    // converter command decode
    wire cmd_fast = wr_cmd & (hwdata[7:0] == `WSC_CMD_FAST);
    wire cmd_slow = wr_cmd & (hwdata[7:0] == `WSC_CMD_SLOW);

    // rate switch sequencer
    always_comb begin
        nxt_rate   = rate_ff;
        nxt_sw_cnt = sw_cnt_ff;
        unique case (rate_ff)
            WSC_RATE_SLOW: begin
                if (cmd_fast && xtal_ff) begin
                    nxt_rate   = WSC_RATE_SWITCH;
                    nxt_sw_cnt = `WSC_SWITCH_CYCLES - 4'h1;
                end
            end
            WSC_RATE_SWITCH: begin
                if (cmd_slow || !nxt_xtal) begin
                    nxt_rate = WSC_RATE_SLOW;
                end else if (sw_cnt_ff == 4'h1) begin
                    nxt_rate = WSC_RATE_FAST;
                end else begin
                    nxt_sw_cnt = sw_cnt_ff - 4'h1;
                end
            end
            WSC_RATE_FAST: begin
                if (cmd_slow || !nxt_xtal) nxt_rate = WSC_RATE_SLOW;
            end
            default: nxt_rate = WSC_RATE_SLOW;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_ff   <= WSC_RATE_SLOW;
            sw_cnt_ff <= 4'h0;
        end else begin
            rate_ff   <= nxt_rate;
            sw_cnt_ff <= nxt_sw_cnt;
        end
    end

    // clock steering outputs
    assign fast_crystal_flag  = xtal_ff;
    assign core_clk_fast      = (rate_ff == WSC_RATE_FAST);
    assign periph_clk_halved  = xtal_ff;
    assign sys_clk_from_ring  = ~fast_xtal_ready;
    assign slow_clk_from_xtal = slow_xtal_select;

    // retained pad controls
    assign pad_ctrl = '{drive_enable: oen_ff, value: out_ff, strength: ds_ff, pull: pe_ff};
    assign pad_oe   = oen_ff;
    assign pad_out  = out_ff & oen_ff;

    // wake detection
    wsc_wake_detect #(.NPINS(NPINS)) u_wake (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .level_sel  (level_ff),
        .wake_en    (wake_en_ff),
        .low_power  (low_power),
        .wake_pin   (wake_pin),
        .wake_event (wake_event),
        .core_reset (core_reset)
    );

    // rate sequencer and halved branch checks
    a_fast_after_ten: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_fast && xtal_ff && rate_ff == WSC_RATE_SLOW) ##1 (!cmd_slow && nxt_xtal) [*8]
        ##1 (!cmd_slow && nxt_xtal) |=> core_clk_fast)
        else $error("fast rate not reached after ten cycles");
    a_rate_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (core_clk_fast && !cmd_slow && nxt_xtal) |=> core_clk_fast)
        else $error("fast rate dropped on its own");
    a_slow_cmd_drops: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_slow |=> !core_clk_fast)
        else $error("slow command ignored");
    a_fast_needs_xtal: assert property (@(posedge hclk) disable iff (!hresetn)
        core_clk_fast |-> fast_crystal_flag)
        else $error("fast rate without 32 MHz");
    a_switch_abort: assert property (@(posedge hclk) disable iff (!hresetn)
        (rate_ff != WSC_RATE_SLOW && !nxt_xtal) |=> !core_clk_fast)
        else $error("rate kept after 16 MHz selected");
    a_halved_branches: assert property (@(posedge hclk) disable iff (!hresetn)
        periph_clk_halved == fast_crystal_flag)
        else $error("halved branches do not follow the crystal flag");

    // register write and readback checks
    a_level_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_level |=> level_ff == $past(hwdata[NPINS-1:0]))
        else $error("level write lost");
    a_wake_en_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_wake |=> wake_en_ff == $past(hwdata[NPINS-1:0]))
        else $error("wake enable write lost");
    a_xtal_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_xtal |=> fast_crystal_flag == $past(hwdata[0]))
        else $error("crystal write lost");
    a_oen_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_oen |=> pad_oe == $past(hwdata[NPINS-1:0]))
        else $error("drive enable write lost");
    a_out_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_out |=> pad_ctrl.value == $past(hwdata[NPINS-1:0]))
        else $error("value write lost");
    a_ds_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ds |=> pad_ctrl.strength == $past(hwdata[NPINS-1:0]))
        else $error("strength write lost");
    a_pe_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pe |=> pad_ctrl.pull == $past(hwdata[NPINS-1:0]))
        else $error("pull write lost");
    a_out_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_req && ra == `WSC_OFS_OUT) |=> hrdata[NPINS-1:0] == out_ff)
        else $error("value readback wrong");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_ff |-> hrdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");

    // pad, wake and clock source checks
    a_pad_gated: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad_out & ~pad_oe) == {NPINS{1'b0}})
        else $error("pad driven while disabled");
    a_wake_match: assert property (@(posedge hclk) disable iff (!hresetn)
        (low_power && wake_en_ff[0] && wake_pin[0] == level_ff[0]) |-> wake_event)
        else $error("enabled wake level missed");
    a_wake_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|wake_en_ff) |-> !wake_event)
        else $error("wake from a blocked pin");
    a_wake_needs_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
        !low_power |-> !wake_event)
        else $error("wake outside low power");
    a_ring_at_start: assert property (@(posedge hclk) disable iff (!hresetn)
        !fast_xtal_ready |-> sys_clk_from_ring)
        else $error("ring not used at start");
    a_slow_source: assert property (@(posedge hclk) disable iff (!hresetn)
        slow_clk_from_xtal == slow_xtal_select)
        else $error("slow clock source wrong");

    c_fast_switch: cover property (@(posedge hclk) disable iff (!hresetn) core_clk_fast);
    c_back_slow:   cover property (@(posedge hclk) disable iff (!hresetn)
        core_clk_fast ##1 !core_clk_fast);
    c_wake:        cover property (@(posedge hclk) disable iff (!hresetn) wake_event);
    c_pad_drive:   cover property (@(posedge hclk) disable iff (!hresetn) |pad_out);
    c_reset_end:   cover property (@(posedge hclk) disable iff (!hresetn)
        core_reset ##1 !core_reset);
endmodule
`default_nettype wire

// ===== core/wsc_wake_detect.sv
// wake decision and core reset pulse generator
`timescale 1ns/1ns
`default_nettype none
`include "wsc_cfg.svh"
module wsc_wake_detect
    import wsc_pkg::*;
#(
    parameter int NPINS = `WSC_NPINS
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // configuration
    input  wire logic [NPINS-1:0] level_sel,
    input  wire logic [NPINS-1:0] wake_en,
    input  wire logic             low_power,
    // pins and results
    input  wire logic [NPINS-1:0] wake_pin,
    output logic                  wake_event,
    output logic                  core_reset
);
    logic [NPINS-1:0] pin_hit;
    logic             any_hit;
    logic [3:0]       rst_cnt_ff;
    logic [3:0]       nxt_rst_cnt;

    // per-pin level match gated by enable
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        assign pin_hit[i] = wake_en[i] & (wake_pin[i] == level_sel[i]);
    end
    assign any_hit    = |pin_hit;
    assign wake_event = low_power & any_hit;
    assign nxt_rst_cnt = wake_event ? `WSC_CORE_RST_CYCLES :
                         (rst_cnt_ff != 4'h0) ? rst_cnt_ff - 4'h1 : 4'h0;
    assign core_reset  = (rst_cnt_ff != 4'h0);

    // core reset stretch counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_ff <= 4'h0;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    a_wake_resets_core: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_event |=> core_reset [*4]) else $error("core reset not stretched");
endmodule
`default_nettype wire
